// File: inc/cgm_pkg.sv
// How it works
// - Loop reference divider offers extra ratios 1280 and 1536 for fast references.
// - Codes 6 and 7 pick those ratios, only when oscillator range is nonzero.
// - With rtc monitor enabled, a stopped or idle rtc oscillator counts as clock loss.
// - Each monitor has a setting choosing reset or interrupt on clock loss.
// - Clock loss sets a per-monitor status flag naming the stopped clock.
// - Fixed-frequency output carries the loop reference at full rate, no halving.
// - Fast internal oscillator passes a programmable power-of-two divider before use.
// - A local selector picks system or rtc oscillator as external loop reference.
// - System oscillator stays available to peripherals while rtc is the reference.
// - Register writes are accepted only from privileged bus accesses.
// - With filter preserve set, switching reference modes keeps the filter value.
// - Enabled pll lock loss raises an interrupt or a system reset, as configured.
// - A lock-loss reset is recorded as reset cause in the reset source status.
// - Reset values of new fields reproduce the former default behaviour.
package cgm_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CGM_CTRL_OFS = 8'h00;
  localparam logic [7:0] CGM_MON_OFS = 8'h04;
  localparam logic [7:0] CGM_STAT_OFS = 8'h08;
  localparam logic [7:0] CGM_MASK_OFS = 8'h0C;
  localparam logic [7:0] CGM_RSTSRC_OFS = 8'h10;
  localparam logic [7:0] CGM_FILT_OFS = 8'h14;

  // ----------------------------------------
  // Control register field positions
  // ----------------------------------------
  localparam int CGM_REFDIV_LSB = 0; // loop_ref_divider_select [2:0]
  localparam int CGM_RANGE_LSB = 3;  // osc_freq_range [4:3]
  localparam int CGM_OSCSEL_BIT = 5; // external reference source
  localparam int CGM_IREFS_BIT = 6;  // internal reference selected
  localparam int CGM_FCRDIV_LSB = 7; // fast internal divider [9:7]
  localparam int CGM_FLTP_BIT = 10;  // filter_value_preserve

  // Monitor register: enables and reset-select bits
  localparam int CGM_CME0_BIT = 0;
  localparam int CGM_RTCMON_BIT = 1; // rtc_osc_monitor_enable
  localparam int CGM_LOLE_BIT = 2;
  localparam int CGM_LOCRE0_BIT = 3;
  localparam int CGM_LOCRE1_BIT = 4;
  localparam int CGM_LOLRE_BIT = 5;

  // Status bits: sys loss, rtc loss, pll lock loss
  localparam int CGM_NUM_EV = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] CGM_CTRL_RST = 32'h0000_0040;
  localparam logic [31:0] CGM_MON_RST = 32'h0000_0018;
  localparam logic [31:0] CGM_FILT_RST = 32'h0000_0080;

  // ----------------------------------------
  // Monitor timing
  // ----------------------------------------
  localparam int CGM_CLK_HZ = 20000000;
  localparam int CGM_LOSS_US = 100;
  localparam int CGM_LOSS_CYC = CGM_LOSS_US * (CGM_CLK_HZ / 1000000);

endpackage : cgm_pkg

// File: logic/cgm_clk_div.sv
`timescale 1ns/10ps
// Step counter; one tick for every cnt_max_i + 1 counted steps
module cgm_clk_div #(
  parameter int WIDTH = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic [WIDTH-1:0] cnt_max_i,
  output logic tick_o
);

  logic [WIDTH-1:0] cnt_reg;

  initial begin
    if (WIDTH < 2) $error("cgm_clk_div: WIDTH too small");
  end

  // ----------------------------------------
  // Count steps to limit, pulse on wrap
  // ----------------------------------------
  // Only steps advance the count, so the output divides the source, not clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (step_i) begin
      cnt_reg <= (cnt_reg >= cnt_max_i) ? '0 : cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= step_i && (cnt_reg >= cnt_max_i);
    end
  end

endmodule : cgm_clk_div

// File: logic/cgm_core.sv
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module cgm_core
  import cgm_pkg::*;
#(
  parameter int LOSS_CYC = cgm_pkg::CGM_LOSS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_priv_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock sources, asynchronous to clk_i
  input wire logic sys_osc_i,
  input wire logic rtc_osc_i,
  input wire logic fast_irc_i,
  input wire logic pll_lock_i,
  input wire logic loop_filter_tracked_i,
  // Clock tree results, sampled in clk_i domain
  output logic loop_ref_tick_o,
  output logic fixed_freq_clock_out_o,
  output logic internal_ref_clock_out_o,
  output logic periph_osc_clk_o,
  output logic ref_internal_o,
  output logic filter_hold_o,
  output logic [1:0] osc_freq_range_o,
  output logic sys_reset_o,
  output logic irq_o
);
  import cgm_pkg::*;

  initial begin
    if (LOSS_CYC < 4) $error("cgm_core: LOSS_CYC too small");
  end

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic [3:0] pin_in;

  assign pin_in = {pll_lock_i, fast_irc_i, rtc_osc_i, sys_osc_i};

  // Two stages before any logic looks at an oscillator or lock pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic sys_edge;
  logic rtc_edge;
  logic irc_edge;
  assign sys_edge = sync2_reg[0] & ~prev_reg[0];
  assign rtc_edge = sync2_reg[1] & ~prev_reg[1];
  assign irc_edge = sync2_reg[2] & ~prev_reg[2];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] mon_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic [1:0] rstsrc_reg;
  logic [7:0] filt_reg;
  logic bus_req;
  logic wr_ok;
  logic rd_stat;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Privileged-only writes; a user write is acknowledged but dropped
  assign wr_ok = bus_req & wb_we_i & wb_priv_i;
  assign rd_stat = bus_req & ~wb_we_i & (wb_adr_i == CGM_STAT_OFS);

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction : merge

  // Control: reset value keeps internal reference, divide 1, no preserve
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CGM_CTRL_RST;
    end else if (wr_ok && wb_adr_i == CGM_CTRL_OFS) begin
      ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_07FF;
    end
  end

  // Monitor control: monitors off, loss of clock resets by default
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_reg <= CGM_MON_RST;
    end else if (wr_ok && wb_adr_i == CGM_MON_OFS) begin
      mon_reg <= merge(mon_reg, wb_dat_i, wb_sel_i) & 32'h0000_003F;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= 3'h0;
    end else if (wr_ok && wb_adr_i == CGM_MASK_OFS && wb_sel_i[0]) begin
      mask_reg <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------
  // Reference divider and mux
  // ----------------------------------------
  logic [2:0] ref_div_code;
  logic [1:0] range;
  logic [10:0] ref_max;
  logic ext_edge;
  logic ref_edge;
  logic [10:0] ref_cnt_reg;

  assign ref_div_code = ctrl_reg[CGM_REFDIV_LSB +: 3];
  assign range = ctrl_reg[CGM_RANGE_LSB +: 2];
  assign osc_freq_range_o = range;

  // Local selector; the system oscillator is never gated by it
  assign ext_edge = ctrl_reg[CGM_OSCSEL_BIT] ? rtc_edge : sys_edge;

  // Ratio minus one; codes 6 and 7 only extend when range is nonzero
  always_comb begin
    if (range == 2'h0) begin
      ref_max = (11'h001 << ref_div_code) - 11'h001;
    end else begin
      unique case (ref_div_code)
        3'h6: ref_max = 11'h4FF; // 1280
        3'h7: ref_max = 11'h5FF; // 1536
        default: ref_max = (11'h020 << ref_div_code) - 11'h001;
      endcase
    end
  end

  assign ref_edge = ctrl_reg[CGM_IREFS_BIT] ? 1'b1 : ext_edge;

  // Counts selected reference edges; slow internal ref is clk-rate here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_reg <= 11'h000;
      loop_ref_tick_o <= 1'b0;
    end else if (ref_edge) begin
      loop_ref_tick_o <= (ref_cnt_reg >= ref_max);
      ref_cnt_reg <= (ref_cnt_reg >= ref_max) ? 11'h000 : ref_cnt_reg + 11'h001;
    end else begin
      loop_ref_tick_o <= 1'b0;
    end
  end

  // Fixed-frequency output follows loop reference directly, no halving
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fixed_freq_clock_out_o <= 1'b0;
    end else begin
      fixed_freq_clock_out_o <= loop_ref_tick_o;
    end
  end

  // System oscillator kept on its own path for peripherals
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_osc_clk_o <= 1'b0;
    end else begin
      periph_osc_clk_o <= sync2_reg[0];
    end
  end

  // ----------------------------------------
  // Fast internal reference divider
  // ----------------------------------------
  logic [2:0] fcrdiv;
  logic irc_tick;
  logic [7:0] irc_max;

  assign fcrdiv = ctrl_reg[CGM_FCRDIV_LSB +: 3];
  assign irc_max = 8'(({7'h00, 1'b1} << fcrdiv) - 8'h01);

  cgm_clk_div #(
    .WIDTH(8)
  ) u_irc_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(irc_edge),
    .cnt_max_i(irc_max),
    .tick_o(irc_tick)
  );

  // Divided fast clock output toggles once per divider wrap of irc edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      internal_ref_clock_out_o <= 1'b0;
    end else if (irc_tick) begin
      internal_ref_clock_out_o <= ~internal_ref_clock_out_o;
    end
  end

  // ----------------------------------------
  // Filter preserve across reference switches
  // ----------------------------------------
  logic irefs_prev_reg;
  logic ref_switch;
  assign ref_switch = irefs_prev_reg ^ ctrl_reg[CGM_IREFS_BIT];
  assign ref_internal_o = ctrl_reg[CGM_IREFS_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irefs_prev_reg <= CGM_CTRL_RST[CGM_IREFS_BIT];
      filt_reg <= CGM_FILT_RST[7:0];
    end else begin
      irefs_prev_reg <= ctrl_reg[CGM_IREFS_BIT];
      // Keep the filter on a switch only when preserve is set
      if (ref_switch && !ctrl_reg[CGM_FLTP_BIT]) begin
        filt_reg <= CGM_FILT_RST[7:0];
      end else if (loop_filter_tracked_i) begin
        filt_reg <= filt_reg + 8'h01;
      end
    end
  end
  assign filter_hold_o = ctrl_reg[CGM_FLTP_BIT];

  // ----------------------------------------
  // Clock monitors
  // ----------------------------------------
  // Watchdog for sys and rtc oscillators: no edge for LOSS_CYC cycles means lost
  logic [31:0] sys_wd_reg;
  logic [31:0] rtc_wd_reg;
  logic sys_lost;
  logic rtc_lost;
  logic lol_prev_reg;
  logic [1:0] lost_prev_reg;
  logic [2:0] ev;

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_edge || !mon_reg[CGM_CME0_BIT]) begin
      sys_wd_reg <= 32'h0;
    end else if (!sys_lost) begin
      sys_wd_reg <= sys_wd_reg + 32'h1;
    end
  end

  // Idle rtc after enable counts too, so a never-started oscillator trips
  always_ff @(posedge clk_i) begin
    if (rst_i || rtc_edge || !mon_reg[CGM_RTCMON_BIT]) begin
      rtc_wd_reg <= 32'h0;
    end else if (!rtc_lost) begin
      rtc_wd_reg <= rtc_wd_reg + 32'h1;
    end
  end

  assign sys_lost = (sys_wd_reg == 32'(LOSS_CYC));
  assign rtc_lost = (rtc_wd_reg == 32'(LOSS_CYC));

  // Edge memory for lock and both loss flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lol_prev_reg <= 1'b0;
      lost_prev_reg <= 2'h0;
    end else begin
      lol_prev_reg <= sync2_reg[3];
      lost_prev_reg <= {rtc_lost, sys_lost};
    end
  end

  // Events are single-cycle: a lasting loss would refill a flag after its read
  assign ev[0] = sys_lost & ~lost_prev_reg[0];
  assign ev[1] = rtc_lost & ~lost_prev_reg[1];
  assign ev[2] = mon_reg[CGM_LOLE_BIT] & lol_prev_reg & ~sync2_reg[3];

  // Sticky flags; a read clears them but a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= (rd_stat ? 3'h0 : stat_reg) | ev;
    end
  end

  // ----------------------------------------
  // Reset or interrupt choice
  // ----------------------------------------
  logic [2:0] rst_sel;
  logic [2:0] rst_req;
  assign rst_sel = {mon_reg[CGM_LOLRE_BIT], mon_reg[CGM_LOCRE1_BIT], mon_reg[CGM_LOCRE0_BIT]};
  assign rst_req = ev & rst_sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= |rst_req;
    end
  end

  // Reset cause survives our own rst_i: it is what software reads after
  always_ff @(posedge clk_i) begin
    if (rst_req[2]) begin
      rstsrc_reg <= 2'h2;
    end else if (|rst_req[1:0]) begin
      rstsrc_reg <= 2'h1;
    end else if (rst_i) begin
      rstsrc_reg <= rstsrc_reg;
    end else if (wr_ok && wb_adr_i == CGM_RSTSRC_OFS) begin
      rstsrc_reg <= 2'h0;
    end
  end

  // Interrupt only for events not routed to reset
  assign irq_o = |(stat_reg & mask_reg & ~rst_sel);

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          CGM_CTRL_OFS: wb_dat_o <= ctrl_reg;
          CGM_MON_OFS: wb_dat_o <= mon_reg;
          CGM_STAT_OFS: wb_dat_o <= {29'h0, stat_reg};
          CGM_MASK_OFS: wb_dat_o <= {29'h0, mask_reg};
          CGM_RSTSRC_OFS: wb_dat_o <= {30'h0, rstsrc_reg};
          CGM_FILT_OFS: wb_dat_o <= {24'h0, filt_reg};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule : cgm_core

// File: verif/cgm_core_asserts.sv
`timescale 1ns/10ps
// ----------------
// Port checker
// ----------------
module cgm_core_asserts #(
  parameter int LOSS_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_priv_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sys_osc_i,
  input wire logic loop_ref_tick_o,
  input wire logic fixed_freq_clock_out_o,
  input wire logic periph_osc_clk_o,
  input wire logic ref_internal_o,
  input wire logic filter_hold_o,
  input wire logic [1:0] osc_freq_range_o,
  input wire logic sys_reset_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers one cycle after a taken request, for one cycle
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // Config outputs only move by reset or a privileged control write
  property p_cfg_hold;
    $changed({osc_freq_range_o, ref_internal_o, filter_hold_o}) |-> $past(rst_i) ||
      (wb_ack_o && wb_we_i && wb_priv_i && wb_adr_i == 8'h00);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
  property p_reset_vals;
    $fell(rst_i) |-> ref_internal_o && !filter_hold_o && osc_freq_range_o == 2'b00 && !irq_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
  // Every reference tick shows on the fixed output, no halving
  property p_ffclk; 1'b1 |=> fixed_freq_clock_out_o == $past(loop_ref_tick_o); endproperty
  a_ffclk: assert property (p_ffclk) else $error("fixed clock lost a tick");
  // Clock-rate internal reference at ratio 1 ticks every cycle; external ticks are single
  property p_tick;
    loop_ref_tick_o && !ref_internal_o && !$past(ref_internal_o) |=> !loop_ref_tick_o;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_periph; $rose(sys_osc_i) |-> ##[1:4] periph_osc_clk_o; endproperty
  a_periph: assert property (p_periph) else $error("periph clock stuck");
  property p_rst_pulse; sys_reset_o |=> !sys_reset_o; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse long");
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  // Main scenarios reached
  c_user_wr: cover property (wb_ack_o && wb_we_i && !wb_priv_i);
  c_reset: cover property (sys_reset_o);
  c_irq: cover property (irq_o);
endmodule : cgm_core_asserts

// File: verif/cgm_osc_model.sv
`timescale 1ns/10ps
// ----------------
// Oscillator sources
// ----------------
module cgm_osc_model (
  input wire logic stop_sys_i,
  input wire logic stop_rtc_i,
  input wire logic unlock_i,
  output logic sys_osc_o,
  output logic rtc_osc_o,
  output logic fast_irc_o,
  output logic pll_lock_o
);
  // System osc, 6 clk periods; parks low when stopped
  initial begin
    sys_osc_o = 1'b0;
    #12;
    forever begin
      #150;
      sys_osc_o = stop_sys_i ? 1'b0 : ~sys_osc_o;
    end
  end
  // Rtc osc, 7 clk periods; stop models a dead crystal
  initial begin
    rtc_osc_o = 1'b0;
    #12;
    forever begin
      #175;
      rtc_osc_o = stop_rtc_i ? 1'b0 : ~rtc_osc_o;
    end
  end
  // Fast irc, 4 clk periods, never stops
  initial begin
    fast_irc_o = 1'b0;
    #12;
    forever begin
      #100;
      fast_irc_o = ~fast_irc_o;
    end
  end
  assign pll_lock_o = ~unlock_i; // Lock drop on demand
endmodule : cgm_osc_model

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import cgm_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, priv, trk, stop_sys, stop_rtc, unlock;
  logic [7:0] adr;
  logic [31:0] dat, rdat, f1, f2;
  logic ack, tick, ffclk, irclk, pclk, refint, fhold, srst, irq, sosc, rosc, firc, lock;
  logic [1:0] rng;
  int error_cnt, checks;
  cgm_core #(.LOSS_CYC(8)) cgm_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_priv_i(priv), .wb_dat_o(rdat), .wb_ack_o(ack), .sys_osc_i(sosc), .rtc_osc_i(rosc),
    .fast_irc_i(firc), .pll_lock_i(lock), .loop_filter_tracked_i(trk),
    .loop_ref_tick_o(tick), .fixed_freq_clock_out_o(ffclk), .internal_ref_clock_out_o(irclk),
    .periph_osc_clk_o(pclk), .ref_internal_o(refint), .filter_hold_o(fhold),
    .osc_freq_range_o(rng), .sys_reset_o(srst), .irq_o(irq));
  cgm_osc_model cgm_osc_model_i (.stop_sys_i(stop_sys), .stop_rtc_i(stop_rtc),
    .unlock_i(unlock), .sys_osc_o(sosc), .rtc_osc_o(rosc), .fast_irc_o(firc), .pll_lock_o(lock));
  // Clock, 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle; waits for ack with a bound, never a fixed count
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic p,
          output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; priv <= p;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    chk("ack", 32'h1, 32'(n < 20));
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d, input logic p);
    logic [31:0] q;
    wb(1'b1, a, d, p, q);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 1'b1, q);
    chk(nm, e, q);
  endtask : rd
  // Cycles between two events: ticks, or toggles of the internal clock
  task meas(input logic s, input int e, input string nm);
    int n;
    logic p, ev;
    p = irclk;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
        ev = s ? (irclk !== p) : (tick === 1'b1);
      end while (!ev && n < 20000);
      p = irclk;
    end
    chk(nm, e, n);
  endtask : meas
  task wait_hi(input logic s, input string nm);
    int n;
    n = 0;
    while ((s ? srst : irq) !== 1'b1 && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, 32'h1, 32'(n < 80));
  endtask : wait_hi
  task summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Watchdog, well above the longest ratio measurement
  initial begin
    #(60000 * 50);
    error_cnt++;
    $display("unexpected run length exp done got hang");
    summarize();
  end
  // ----------------
  // Test sequence
  // ----------------
  initial begin
    error_cnt = 0; checks = 0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    priv = 1'b0; trk = 1'b0; stop_sys = 1'b0; stop_rtc = 1'b0; unlock = 1'b0;
    adr = 8'h00; dat = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CGM_CTRL_OFS, CGM_CTRL_RST, "ctrl");
    rd(CGM_MON_OFS, CGM_MON_RST, "mon");
    rd(CGM_FILT_OFS, CGM_FILT_RST, "filt");
    wr(CGM_CTRL_OFS, 32'h0000_07FF, 1'b0);
    wr(CGM_MON_OFS, 32'h0000_003F, 1'b0);
    wr(8'h18, 32'hFFFF_FFFF, 1'b1);
    rd(CGM_CTRL_OFS, CGM_CTRL_RST, "ctrl_user");
    rd(CGM_MON_OFS, CGM_MON_RST, "mon_user");
    rd(8'h18, 32'h0, "unmapped");
    $display("test access done");
    // Ratios: sys osc reference, 6 cycles per period
    wr(CGM_CTRL_OFS, 32'h0000_0000, 1'b1);
    meas(1'b0, 6, "ratio_1");
    meas(1'b1, 4, "irc_div1");
    wr(CGM_CTRL_OFS, 32'h0000_0006, 1'b1);
    meas(1'b0, 384, "ratio_64");
    wr(CGM_CTRL_OFS, 32'h0000_0100, 1'b1);
    meas(1'b1, 16, "irc_div4");
    wr(CGM_CTRL_OFS, 32'h0000_040E, 1'b1);
    chk("range", 32'h1, 32'(rng));
    chk("ref_int", 32'h0, 32'(refint));
    meas(1'b0, 7680, "ratio_1280");
    wr(CGM_CTRL_OFS, 32'h0000_040F, 1'b1);
    meas(1'b0, 9216, "ratio_1536");
    $display("test ratios done");
    // Filter kept across an internal to external switch
    wr(CGM_CTRL_OFS, 32'h0000_0440, 1'b1);
    repeat (3) begin
      @(posedge clk_i);
      trk <= 1'b1;
      @(posedge clk_i);
      trk <= 1'b0;
    end
    wb(1'b0, CGM_FILT_OFS, 32'h0, 1'b1, f1);
    wr(CGM_CTRL_OFS, 32'h0000_0400, 1'b1);
    wb(1'b0, CGM_FILT_OFS, 32'h0, 1'b1, f2);
    chk("filt_keep", f1, f2);
    chk("hold", 32'h1, 32'(fhold));
    wr(CGM_CTRL_OFS, 32'h0000_0040, 1'b1);
    rd(CGM_FILT_OFS, CGM_FILT_RST, "filt_drop");
    $display("test filter done");
    // Rtc loss as interrupt, then read-to-clear
    wr(CGM_MON_OFS, 32'h0000_0002, 1'b1);
    wr(CGM_MASK_OFS, 32'h0000_0002, 1'b1);
    stop_rtc <= 1'b1;
    wait_hi(1'b0, "rtc_irq");
    rd(CGM_STAT_OFS, 32'h2, "stat_rtc");
    repeat (2) @(posedge clk_i);
    chk("irq_clr", 32'h0, 32'(irq));
    stop_rtc <= 1'b0;
    $display("test rtc done");
    // Lock loss and sys loss as resets, cause recorded
    wr(CGM_RSTSRC_OFS, 32'h0, 1'b1);
    wr(CGM_MON_OFS, 32'h0000_0024, 1'b1);
    unlock <= 1'b1;
    wait_hi(1'b1, "lol_reset");
    rd(CGM_RSTSRC_OFS, 32'h2, "src_lol");
    rd(CGM_STAT_OFS, 32'h4, "stat_lol");
    unlock <= 1'b0;
    wr(CGM_RSTSRC_OFS, 32'h0, 1'b1);
    wr(CGM_MON_OFS, 32'h0000_0009, 1'b1);
    stop_sys <= 1'b1;
    wait_hi(1'b1, "sys_reset");
    rd(CGM_RSTSRC_OFS, 32'h1, "src_sys");
    // Our own reset must leave the recorded cause in place
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CGM_RSTSRC_OFS, 32'h1, "src_kept");
    rd(CGM_MON_OFS, CGM_MON_RST, "mon_again");
    $display("test resets done");
    summarize();
  end
endmodule : tb_top
bind cgm_core cgm_core_asserts #(.LOSS_CYC(LOSS_CYC)) cgm_core_asserts_i (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_priv_i(wb_priv_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sys_osc_i(sys_osc_i), .loop_ref_tick_o(loop_ref_tick_o),
  .fixed_freq_clock_out_o(fixed_freq_clock_out_o), .periph_osc_clk_o(periph_osc_clk_o),
  .ref_internal_o(ref_internal_o), .filter_hold_o(filter_hold_o),
  .osc_freq_range_o(osc_freq_range_o), .sys_reset_o(sys_reset_o), .irq_o(irq_o));
